// ===== design/rxcr_params.svh
// Offsets, field positions and reset values of the detector/recovery bank
`ifndef RXCR_PARAMS_SVH
`define RXCR_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define RXCR_IDX_PROP_A 8'h73
`define RXCR_IDX_INTEG_A 8'h74
`define RXCR_IDX_RUNIN_A 8'h75
`define RXCR_IDX_SYNC_SEARCH_TIMEOUT_A 8'h76
`define RXCR_IDX_WIN_A 8'h77
`define RXCR_IDX_PROP_B 8'h93
`define RXCR_IDX_INTEG_B 8'h94
`define RXCR_IDX_RUNIN_B 8'h95
`define RXCR_IDX_SYNC_SEARCH_TIMEOUT_B 8'h96
`define RXCR_IDX_WIN_B 8'h97
`define RXCR_IDX_PSLC_A 8'hB4
`define RXCR_IDX_PSLC_B 8'hB5
`define RXCR_IDX_LOWLVL_A 8'hB6
`define RXCR_IDX_LOWLVL_B 8'hB7
`define RXCR_IDX_FACT_A 8'hB8
`define RXCR_IDX_FACT_B 8'hB9
`define RXCR_IDX_STATUS 8'hBA

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RXCR_PSLC_OFF_BIT 7
`define RXCR_SRC_SEL_BIT 7
`define RXCR_MANUAL_BIT 6
`define RXCR_LOW_FACT_LSB 2

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define RXCR_RST_ZERO 8'h00
`define RXCR_RST_PSLC 8'h80
`define RXCR_RST_FACT 8'h0A
`define RXCR_MASK_FULL 8'hFF
`define RXCR_MASK_RUNIN 8'h03
`define RXCR_MASK_FACT 8'h0F

`endif

// ===== design/rxcr_pkg.sv
// Types shared by the detector/recovery configuration bank
package rxcr_pkg;
    // Slot of a register within one configuration set
    typedef enum logic [2:0] {
        RXCR_SLOT_PROP = 3'h0,
        RXCR_SLOT_INTEG = 3'h1,
        RXCR_SLOT_RUNIN = 3'h2,
        RXCR_SLOT_SYNC_SEARCH_TIMEOUT = 3'h3,
        RXCR_SLOT_WIN = 3'h4,
        RXCR_SLOT_PSLC = 3'h5,
        RXCR_SLOT_LOWLVL = 3'h6,
        RXCR_SLOT_FACT = 3'h7
    } rxcr_slot_t;

    // Noise detector selection
    typedef enum logic [1:0] {
        RXCR_ND_SQUELCH = 2'h0,
        RXCR_ND_NOISE = 2'h1,
        RXCR_ND_BOTH = 2'h2,
        RXCR_ND_LOW = 2'h3
    } rxcr_nd_sel_t;

    // Address decode result
    typedef struct packed {
        logic hit;
        logic status;
        logic set_b;
        rxcr_slot_t slot;
    } rxcr_dec_t;

    typedef logic [7:0] rxcr_byte_t;
endpackage

// ===== design/rxcr_cfg_set.sv
// One configuration set (copy A or B) of the bank
`timescale 1ns/10ps
`default_nettype none
`include "rxcr_params.svh"

module rxcr_cfg_set (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Write port
    input wire logic wr_en,
    input wire rxcr_pkg::rxcr_slot_t wr_slot,
    input wire rxcr_pkg::rxcr_byte_t wr_data,
    // Register contents
    output rxcr_pkg::rxcr_byte_t regs_q [8]
);
    import rxcr_pkg::*;

    // ----------------------------------------
    // Storage, one slot per register
    // ----------------------------------------
    for (genvar s = 0; s < 8; s++) begin : g_slot
        localparam rxcr_byte_t RST = (s == 5) ? `RXCR_RST_PSLC :
            (s == 7) ? `RXCR_RST_FACT : `RXCR_RST_ZERO;
        localparam rxcr_byte_t MASK = (s == 2) ? `RXCR_MASK_RUNIN :
            (s == 7) ? `RXCR_MASK_FACT : `RXCR_MASK_FULL;

        // Unused bits drop on write
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                regs_q[s] <= RST;
            end else if (wr_en && wr_slot == rxcr_slot_t'(s)) begin
                regs_q[s] <= wr_data & MASK;
            end
        end
    end
endmodule
`default_nettype wire

// ===== design/rxcr_bank.sv
// Detector and clock recovery configuration bank with APB access
// ----------------------------------------
// Summary of operation
// - Two copies A and B of each register except status, at their own addresses.
// - Pre-slicer off bit 7 set disables it, default; clear enables.
// - Source bit 7 picks ASK noise or low-level signal for status.
// - Source bit set makes low level readable through noise status.
// - Manual bit 6 picks factor register, else data-rate automatic factor.
// - Low threshold acts only with noise selection 11b.
// - Low range factor codes divide by 2, 4, 6, 8; default 10b.
// - Main range factor codes divide by 4, 6, 8, 10; default 10b.
// - Detector value is divided by the chosen factor before comparing.
// - Run-in field bits 1:0 sets run-in length; 01b is 3.5 bits.
// - Sync search timeout counts sixteenths of a bit.
// - Violation window length counts sixteenths of a bit.
// - Selection 11b gates noise detect by low threshold exceeded.
// ----------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "rxcr_params.svh"

module rxcr_bank (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receiver context
    input wire logic set_sel,
    input wire rxcr_pkg::rxcr_nd_sel_t nd_sel,
    input wire logic [1:0] auto_range_factor,
    // Detector inputs
    input wire rxcr_pkg::rxcr_byte_t sig_det_level,
    input wire rxcr_pkg::rxcr_byte_t low_det_level,
    input wire rxcr_pkg::rxcr_byte_t ask_noise_power,
    input wire logic fsk_noise_det,
    // Detector results
    output rxcr_pkg::rxcr_byte_t main_level_scaled,
    output rxcr_pkg::rxcr_byte_t low_level_scaled,
    output logic low_level_exceeded,
    output logic fsk_noise_valid,
    // Pre-slicer settings
    output logic pre_slicer_enable,
    output logic [1:0] pre_slicer_hysteresis,
    output logic [4:0] pre_slicer_threshold,
    // Clock recovery settings
    output logic [1:0] peak_slew_rate,
    output logic [1:0] phase_error_tolerance,
    output logic [1:0] proportional_value,
    output logic [1:0] proportional_saturation,
    output logic [1:0] correlator_saturation,
    output logic [1:0] loop_filter_saturation,
    output logic [1:0] integral_value,
    output logic [1:0] integral_saturation,
    output logic [1:0] runin_length,
    // Frame synchronizer settings
    output rxcr_pkg::rxcr_byte_t sync_search_timeout,
    output rxcr_pkg::rxcr_byte_t violation_window_length
);
    import rxcr_pkg::*;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Map a word index onto set and slot
    function automatic rxcr_dec_t decode(input logic [11:0] a);
        rxcr_dec_t d;
        d = '0;
        d.hit = (a[1:0] == 2'h0) && (a[11:10] == 2'h0);
        case (a[9:2])
            `RXCR_IDX_PROP_A: d.slot = RXCR_SLOT_PROP;
            `RXCR_IDX_INTEG_A: d.slot = RXCR_SLOT_INTEG;
            `RXCR_IDX_RUNIN_A: d.slot = RXCR_SLOT_RUNIN;
            `RXCR_IDX_SYNC_SEARCH_TIMEOUT_A: d.slot = RXCR_SLOT_SYNC_SEARCH_TIMEOUT;
            `RXCR_IDX_WIN_A: d.slot = RXCR_SLOT_WIN;
            `RXCR_IDX_PSLC_A: d.slot = RXCR_SLOT_PSLC;
            `RXCR_IDX_LOWLVL_A: d.slot = RXCR_SLOT_LOWLVL;
            `RXCR_IDX_FACT_A: d.slot = RXCR_SLOT_FACT;
            `RXCR_IDX_PROP_B: begin
                d.set_b = 1'b1;
                d.slot = RXCR_SLOT_PROP;
            end
            `RXCR_IDX_INTEG_B: begin
                d.set_b = 1'b1;
                d.slot = RXCR_SLOT_INTEG;
            end
            `RXCR_IDX_RUNIN_B: begin
                d.set_b = 1'b1;
                d.slot = RXCR_SLOT_RUNIN;
            end
            `RXCR_IDX_SYNC_SEARCH_TIMEOUT_B: begin
                d.set_b = 1'b1;
                d.slot = RXCR_SLOT_SYNC_SEARCH_TIMEOUT;
            end
            `RXCR_IDX_WIN_B: begin
                d.set_b = 1'b1;
                d.slot = RXCR_SLOT_WIN;
            end
            `RXCR_IDX_PSLC_B: begin
                d.set_b = 1'b1;
                d.slot = RXCR_SLOT_PSLC;
            end
            `RXCR_IDX_LOWLVL_B: begin
                d.set_b = 1'b1;
                d.slot = RXCR_SLOT_LOWLVL;
            end
            `RXCR_IDX_FACT_B: begin
                d.set_b = 1'b1;
                d.slot = RXCR_SLOT_FACT;
            end
            `RXCR_IDX_STATUS: d.status = d.hit;
            default: d.hit = 1'b0;
        endcase
        return d;
    endfunction

    // Main range: 4, 6, 8, 10
    function automatic rxcr_byte_t div_main(input rxcr_byte_t v,
                                            input logic [1:0] c);
        case (c)
            2'h0: return v / 8'h04;
            2'h1: return v / 8'h06;
            2'h2: return v / 8'h08;
            default: return v / 8'h0A;
        endcase
    endfunction

    // Low range: 2, 4, 6, 8
    function automatic rxcr_byte_t div_low(input rxcr_byte_t v,
                                           input logic [1:0] c);
        case (c)
            2'h0: return v / 8'h02;
            2'h1: return v / 8'h04;
            2'h2: return v / 8'h06;
            default: return v / 8'h08;
        endcase
    endfunction

    // ----------------------------------------
    // APB access
    // ----------------------------------------
    rxcr_dec_t dec;
    logic wr_fire;
    rxcr_byte_t regs [2][8];
    rxcr_byte_t status_val;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // Decode and write strobe
    assign dec = decode(paddr);
    assign wr_fire = psel && penable && pwrite && dec.hit && !dec.status;
    assign pready = psel && penable;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // Answer prepared during the setup cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_q <= !dec.hit || (pwrite && dec.status);
            if (!pwrite && dec.status) begin
                prdata_q <= {24'h00_0000, status_val};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // Two independent register copies
    // ----------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_set
        rxcr_cfg_set u_set (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .wr_en(wr_fire && (dec.set_b == 1'(g))),
            .wr_slot(dec.slot),
            .wr_data(pwdata[7:0]),
            .regs_q(regs[g])
        );
    end

    // ----------------------------------------
    // Active set and detector scaling
    // ----------------------------------------
    rxcr_byte_t act_pslc, act_low, act_fact;
    logic [1:0] main_code;
    rxcr_byte_t main_div, low_div;
    logic low_exc;

    // Active set chosen by the receiver
    assign act_pslc = regs[set_sel][RXCR_SLOT_PSLC];
    assign act_low = regs[set_sel][RXCR_SLOT_LOWLVL];
    assign act_fact = regs[set_sel][RXCR_SLOT_FACT];

    // Range factor source and division
    assign main_code = act_low[`RXCR_MANUAL_BIT] ?
        act_fact[1:0] : auto_range_factor;
    assign main_div = div_main(sig_det_level, main_code);
    assign low_div = div_low(low_det_level,
        act_fact[`RXCR_LOW_FACT_LSB +: 2]);
    assign low_exc = (nd_sel == RXCR_ND_LOW) &&
        (low_div > {2'h0, act_low[5:0]});

    // Noise status source
    assign status_val = act_low[`RXCR_SRC_SEL_BIT] ?
        low_div : ask_noise_power;

    // Registered detector results
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            main_level_scaled <= 8'h00;
            low_level_scaled <= 8'h00;
            low_level_exceeded <= 1'b0;
            fsk_noise_valid <= 1'b0;
        end else begin
            main_level_scaled <= main_div;
            low_level_scaled <= low_div;
            low_level_exceeded <= low_exc;
            case (nd_sel)
                RXCR_ND_SQUELCH: fsk_noise_valid <= 1'b0;
                RXCR_ND_LOW: fsk_noise_valid <= fsk_noise_det && low_exc;
                default: fsk_noise_valid <= fsk_noise_det;
            endcase
        end
    end

    // ----------------------------------------
    // Registered configuration outputs
    // ----------------------------------------
    rxcr_byte_t act_prop, act_integ;
    assign act_prop = regs[set_sel][RXCR_SLOT_PROP];
    assign act_integ = regs[set_sel][RXCR_SLOT_INTEG];

    // Pre-slicer fields
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_slicer_enable <= 1'b0;
            pre_slicer_hysteresis <= 2'h0;
            pre_slicer_threshold <= 5'h00;
        end else begin
            pre_slicer_enable <= !act_pslc[`RXCR_PSLC_OFF_BIT];
            pre_slicer_hysteresis <= act_pslc[6:5];
            pre_slicer_threshold <= act_pslc[4:0];
        end
    end

    // Clock recovery and framer fields
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            peak_slew_rate <= 2'h0;
            phase_error_tolerance <= 2'h0;
            proportional_value <= 2'h0;
            proportional_saturation <= 2'h0;
            correlator_saturation <= 2'h0;
            loop_filter_saturation <= 2'h0;
            integral_value <= 2'h0;
            integral_saturation <= 2'h0;
            runin_length <= 2'h0;
            sync_search_timeout <= 8'h00;
            violation_window_length <= 8'h00;
        end else begin
            peak_slew_rate <= act_prop[7:6];
            phase_error_tolerance <= act_prop[5:4];
            proportional_value <= act_prop[3:2];
            proportional_saturation <= act_prop[1:0];
            correlator_saturation <= act_integ[7:6];
            loop_filter_saturation <= act_integ[5:4];
            integral_value <= act_integ[3:2];
            integral_saturation <= act_integ[1:0];
            runin_length <= regs[set_sel][RXCR_SLOT_RUNIN][1:0];
            sync_search_timeout <= regs[set_sel][RXCR_SLOT_SYNC_SEARCH_TIMEOUT];
            violation_window_length <= regs[set_sel][RXCR_SLOT_WIN];
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_wr_a_win;
        wr_fire && !dec.set_b && dec.slot == RXCR_SLOT_WIN;
    endsequence

    a_copy_write: assert property (
        s_wr_a_win |=> regs[0][RXCR_SLOT_WIN] == $past(pwdata[7:0]))
        else $error("set A window write not stored");

    a_copy_isolate: assert property (
        wr_fire && !dec.set_b |=>
        regs[1][RXCR_SLOT_WIN] == $past(regs[1][RXCR_SLOT_WIN]))
        else $error("write to set A changed set B");

    a_pslc_enable: assert property (
        ##1 pre_slicer_enable == !$past(act_pslc[7]))
        else $error("pre-slicer enable wrong");

    a_status_src: assert property (
        act_low[7] |-> status_val == low_div)
        else $error("noise status source wrong");

    a_status_read: assert property (
        psel && !penable && !pwrite && dec.status
        |=> prdata_q[7:0] == $past(status_val) && !pslverr)
        else $error("status read data wrong");

    a_manual_range: assert property (
        act_low[6] && act_fact[1:0] == 2'h3
        |=> main_level_scaled == $past(sig_det_level) / 8'h0A)
        else $error("manual range factor not applied");

    a_low_gate: assert property (
        nd_sel != RXCR_ND_LOW |=> !low_level_exceeded)
        else $error("low threshold active outside mode 11b");

    a_low_divide: assert property (
        act_fact[3:2] == 2'h0
        |=> low_level_scaled == $past(low_det_level) / 8'h02)
        else $error("low range divide by two wrong");

    a_noise_gate: assert property (
        nd_sel == RXCR_ND_LOW && !low_exc |=> !fsk_noise_valid)
        else $error("noise valid without low threshold");

    a_runin_mask: assert property (
        regs[0][RXCR_SLOT_RUNIN][7:2] == 6'h00)
        else $error("unused run-in bits stored");

    a_timeout_pass: assert property (
        $stable(regs[set_sel][RXCR_SLOT_SYNC_SEARCH_TIMEOUT]) && $stable(set_sel)
        |=> sync_search_timeout == $past(regs[set_sel][RXCR_SLOT_SYNC_SEARCH_TIMEOUT]))
        else $error("sync timeout output stale");
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the detector and clock recovery configuration bank
`timescale 1ns/10ps
`default_nettype none
`include "rxcr_params.svh"

module tb_top;
    import rxcr_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic set_sel, fsk_noise_det, low_level_exceeded, fsk_noise_valid, pre_slicer_enable;
    rxcr_nd_sel_t nd_sel;
    logic [1:0] auto_range_factor, pre_slicer_hysteresis, peak_slew_rate, phase_error_tolerance;
    logic [1:0] proportional_value, proportional_saturation, correlator_saturation;
    logic [1:0] loop_filter_saturation, integral_value, integral_saturation, runin_length;
    logic [4:0] pre_slicer_threshold;
    rxcr_byte_t sig_det_level, low_det_level, ask_noise_power, main_level_scaled;
    rxcr_byte_t low_level_scaled, sync_search_timeout, violation_window_length;
    int errors, total_checks, cycles;

    rxcr_bank rxcr_bank_i (
        .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .set_sel, .nd_sel, .auto_range_factor, .sig_det_level, .low_det_level,
        .ask_noise_power, .fsk_noise_det, .main_level_scaled, .low_level_scaled,
        .low_level_exceeded, .fsk_noise_valid, .pre_slicer_enable, .pre_slicer_hysteresis,
        .pre_slicer_threshold, .peak_slew_rate, .phase_error_tolerance, .proportional_value,
        .proportional_saturation, .correlator_saturation, .loop_filter_saturation,
        .integral_value, .integral_saturation, .runin_length, .sync_search_timeout,
        .violation_window_length
    );

    // ----------------------------------------
    // Clock, timeout and reporting
    // ----------------------------------------
    // Free running system clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Cuts a hung run short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ----------------------------------------
    // Bus and timing helpers
    // ----------------------------------------
    // Waits for pready as long as it takes; only the bench timeout ends a hang
    task automatic apb(input logic is_wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= is_wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'hA5A5A5, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        logic e;
        apb(1'b1, idx, wd, rd, e);
        chk(e, 1'b0);
    endtask

    // Lets registered outputs catch up with settled inputs
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [31:0] rd;
        logic e;
        logic [7:0] idx;
        settle();
        chk(pre_slicer_enable, 1'b0);
        chk({pre_slicer_hysteresis, pre_slicer_threshold}, 7'h00);
        chk({runin_length, sync_search_timeout, violation_window_length}, 18'h0);
        chk(main_level_scaled, 8'd24);
        chk(low_level_scaled, 8'd40);
        for (int i = 0; i < 16; i++) begin
            idx = (i < 5) ? 8'(8'h73 + i) : (i < 10) ? 8'(8'h8E + i) : 8'(8'hAA + i);
            apb(1'b0, idx, 8'h00, rd, e);
            chk(rd, 32'h0);
            chk(e, 1'b0);
        end
    endtask

    task automatic t_copies();
        wr(`RXCR_IDX_PROP_A, 8'hD6);
        wr(`RXCR_IDX_INTEG_A, 8'h65);
        wr(`RXCR_IDX_RUNIN_A, 8'hFD);
        wr(`RXCR_IDX_SYNC_SEARCH_TIMEOUT_A, 8'hFF);
        wr(`RXCR_IDX_WIN_A, 8'h30);
        wr(`RXCR_IDX_PSLC_A, 8'h32);
        wr(`RXCR_IDX_PROP_B, 8'h29);
        wr(`RXCR_IDX_INTEG_B, 8'h96);
        wr(`RXCR_IDX_WIN_B, 8'hFF);
        settle();
        chk({peak_slew_rate, phase_error_tolerance, proportional_value,
             proportional_saturation}, 8'hD6);
        chk({correlator_saturation, loop_filter_saturation, integral_value,
             integral_saturation}, 8'h65);
        chk(runin_length, 2'b01);
        chk({sync_search_timeout, violation_window_length}, 16'hFF30);
        chk({pre_slicer_enable, pre_slicer_hysteresis, pre_slicer_threshold}, 8'hB2);
        @(posedge sys_clk);
        set_sel <= 1'b1;
        settle();
        chk({peak_slew_rate, phase_error_tolerance, proportional_value,
             proportional_saturation}, 8'h29);
        chk({correlator_saturation, loop_filter_saturation, integral_value,
             integral_saturation}, 8'h96);
        chk({runin_length, sync_search_timeout, violation_window_length}, 18'h000FF);
        chk(pre_slicer_enable, 1'b0);
        @(posedge sys_clk);
        set_sel <= 1'b0;
    endtask

    task automatic t_factors();
        @(posedge sys_clk);
        sig_det_level <= 8'd240;
        low_det_level <= 8'd240;
        wr(`RXCR_IDX_LOWLVL_A, 8'h40);
        for (int i = 0; i < 4; i++) begin
            wr(`RXCR_IDX_FACT_A, 8'hF0 | 8'(i * 5));
            settle();
            chk(main_level_scaled, 240 / (4 + 2 * i));
            chk(low_level_scaled, 240 / (2 + 2 * i));
        end
        wr(`RXCR_IDX_LOWLVL_A, 8'h00);
        @(posedge sys_clk);
        auto_range_factor <= 2'b00;
        settle();
        chk(main_level_scaled, 8'd60);
    endtask

    task automatic t_thresh();
        logic hit;
        wr(`RXCR_IDX_FACT_A, 8'h00);
        wr(`RXCR_IDX_LOWLVL_A, 8'h09);
        for (int lvl = 18; lvl <= 20; lvl += 2) begin
            for (int n = 0; n < 4; n++) begin
                @(posedge sys_clk);
                low_det_level <= 8'(lvl);
                nd_sel <= rxcr_nd_sel_t'(n);
                settle();
                hit = (n == 3) && (lvl == 20);
                chk(low_level_exceeded, hit);
                chk(fsk_noise_valid, (n == 0) ? 1'b0 : ((n == 3) ? hit : 1'b1));
            end
        end
        // Raw detect low must pass through as low
        @(posedge sys_clk);
        fsk_noise_det <= 1'b0;
        nd_sel <= RXCR_ND_NOISE;
        settle();
        chk(fsk_noise_valid, 1'b0);
        @(posedge sys_clk);
        fsk_noise_det <= 1'b1;
    endtask

    task automatic t_status();
        logic [31:0] rd;
        logic e;
        @(posedge sys_clk);
        ask_noise_power <= 8'h5A;
        low_det_level <= 8'd100;
        wr(`RXCR_IDX_LOWLVL_A, 8'h00);
        apb(1'b0, `RXCR_IDX_STATUS, 8'h00, rd, e);
        chk(rd, 32'h5A);
        wr(`RXCR_IDX_LOWLVL_A, 8'h80);
        apb(1'b0, `RXCR_IDX_STATUS, 8'h00, rd, e);
        chk(rd, 32'h32);
        chk(e, 1'b0);
        apb(1'b1, `RXCR_IDX_STATUS, 8'h11, rd, e);
        chk(e, 1'b1);
        apb(1'b0, 8'h00, 8'h00, rd, e);
        chk(e, 1'b1);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        errors = 0;
        total_checks = 0;
        cycles = 0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        set_sel = 1'b0;
        nd_sel = RXCR_ND_SQUELCH;
        auto_range_factor = 2'b11;
        sig_det_level = 8'd240;
        low_det_level = 8'd240;
        ask_noise_power = 8'h00;
        fsk_noise_det = 1'b1;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_copies();
        t_factors();
        t_thresh();
        t_status();
        wrap_up();
    end
endmodule
`default_nettype wire
